/* File: design/adcs_pkg.sv */
// Shared constants and state types for the converter register block.
`default_nettype none
package adcs_pkg;
    localparam logic [7:0] ADDR_CLK_DIV = 8'hF2;
    localparam logic [7:0] ADDR_CONTROL = 8'hF3;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hF4;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hF5;
    localparam logic [7:0] ADDR_PIN_SELECT = 8'hF6;
    localparam int CTRL_PRECISION_BIT = 6;
    localparam int CTRL_POWER_BIT = 5;
    localparam int CTRL_DONE_BIT = 4;
    localparam int CTRL_START_BIT = 3;
    localparam int CHANNEL_W = 3;
    localparam int DIV_FIELD_W = 5;
    localparam int RESULT_W = 10;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] CONV_CLOCKS = 4'hB;
    localparam logic [3:0] CONV_LAST = CONV_CLOCKS - 4'h1;
    localparam logic [7:0] BASE_STANDARD = 8'h04;
    localparam logic [7:0] BASE_DOUBLE = 8'h02;

    typedef struct packed {
        logic precision;
        logic power_on;
        logic done_flag;
        logic start_bit;
        logic [CHANNEL_W-1:0] channel;
        logic [DIV_FIELD_W-1:0] clk_div;
        logic [7:0] pin_sel;
        logic [RESULT_W-1:0] result;
        logic [3:0] clk_count;
        logic [7:0] rdata;
    } adcs_state_t;

    typedef struct packed {
        logic [7:0] count;
    } adcs_div_state_t;
endpackage : adcs_pkg
`default_nettype wire

/* File: design/adcs_prescaler.sv */
// Converter clock prescaler producing one tick per converter clock period.
`default_nettype none
module adcs_prescaler (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic run_in,
    input wire logic [4:0] div_field_in,
    input wire logic double_speed_in,
    output logic tick_out
);
    adcs_pkg::adcs_div_state_t s;
    adcs_pkg::adcs_div_state_t next_s;
    logic [7:0] base;
    logic [7:0] limit;

    always_comb begin
        base = double_speed_in ? adcs_pkg::BASE_DOUBLE
                               : adcs_pkg::BASE_STANDARD;
        limit = 8'(({3'h0, div_field_in} + 8'h01) * base);
        tick_out = run_in && (s.count == limit - 8'h01);
        next_s = s;
        if (!run_in || tick_out) begin
            next_s.count = 8'h00;
        end else begin
            next_s.count = s.count + 8'h01;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : adcs_prescaler
`default_nettype wire

/* File: design/adcs_sfr_control.sv */
// Special function register control of the eight-channel 10-bit converter.
// How it works
// - Pin-select bits 7..0 route port pins 7..0 to the converter.
// - Finished conversion sets the done flag; only a zero write clears it.
// - Done flag requests the interrupt while the interrupt enable is set.
// - Field bits 4..0 divide the CPU clock by base times field plus one.
// - High result register shows result bits 9..2, resets to zero.
// - Low result register shows result bits 1..0, resets to zero.
// - Start bit launches one conversion; hardware clears it on completion.
// - Channel field 2..0 selects input 0..7 by binary value.
// - Clearing power-on bit puts converter in standby with no conversion.
// - Precision bit halts the CPU while a conversion runs.
`default_nettype none
module adcs_sfr_control (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic converter_irq_enable_in,
    input wire logic double_speed_clock_mode_in,
    input wire logic [9:0] adc_data_in,
    output logic [7:0] pin_analog_select_out,
    output logic [2:0] input_channel_out,
    output logic converter_power_on_out,
    output logic conversion_active_out,
    output logic converter_clk_tick_out,
    output logic precision_cpu_halt_out,
    output logic converter_irq_out
);
    adcs_pkg::adcs_state_t s;
    adcs_pkg::adcs_state_t next_s;
    logic tick;
    logic wr_ctrl;
    logic start_ok;

    // The conversion timer only runs while a conversion is in flight.
    adcs_prescaler u_prescaler (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .run_in(s.start_bit),
        .div_field_in(s.clk_div),
        .double_speed_in(double_speed_clock_mode_in),
        .tick_out(tick)
    );

    assign wr_ctrl = sfr_wr_in && (sfr_addr_in == adcs_pkg::ADDR_CONTROL);
    // A start on a channel whose pin is not routed is dropped.
    assign start_ok = sfr_wdata_in[adcs_pkg::CTRL_START_BIT]
        && sfr_wdata_in[adcs_pkg::CTRL_POWER_BIT]
        && s.pin_sel[sfr_wdata_in[2:0]] && !s.start_bit;

    always_comb begin
        next_s = s;
        if (sfr_rd_in) begin
            unique case (sfr_addr_in)
                adcs_pkg::ADDR_CLK_DIV: next_s.rdata = {3'h0, s.clk_div};
                adcs_pkg::ADDR_CONTROL: next_s.rdata = {1'b0, s.precision,
                    s.power_on, s.done_flag, s.start_bit, s.channel};
                adcs_pkg::ADDR_RESULT_LOW:
                    next_s.rdata = {6'h00, s.result[1:0]};
                adcs_pkg::ADDR_RESULT_HIGH:
                    next_s.rdata = s.result[9:2];
                adcs_pkg::ADDR_PIN_SELECT: next_s.rdata = s.pin_sel;
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (sfr_wr_in) begin
            unique case (sfr_addr_in)
                adcs_pkg::ADDR_CLK_DIV:
                    next_s.clk_div = sfr_wdata_in[4:0];
                adcs_pkg::ADDR_PIN_SELECT:
                    next_s.pin_sel = sfr_wdata_in;
                adcs_pkg::ADDR_CONTROL: begin
                    next_s.precision =
                        sfr_wdata_in[adcs_pkg::CTRL_PRECISION_BIT];
                    next_s.power_on = sfr_wdata_in[adcs_pkg::CTRL_POWER_BIT];
                    next_s.channel = sfr_wdata_in[2:0];
                    if (!sfr_wdata_in[adcs_pkg::CTRL_DONE_BIT]) begin
                        next_s.done_flag = 1'b0;
                    end
                    if (start_ok) begin
                        next_s.start_bit = 1'b1;
                        next_s.clk_count = 4'h0;
                    end
                end
                default: ;
            endcase
        end
        // Completion follows the clear so that a finishing conversion wins.
        if (s.start_bit && tick) begin
            if (s.clk_count == adcs_pkg::CONV_LAST) begin
                next_s.result = adc_data_in;
                next_s.done_flag = 1'b1;
                next_s.start_bit = 1'b0;
            end else begin
                next_s.clk_count = s.clk_count + 4'h1;
            end
        end
        if (!next_s.power_on) begin
            next_s.start_bit = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata_out = s.rdata;
    assign pin_analog_select_out = s.pin_sel;
    assign input_channel_out = s.channel;
    assign converter_power_on_out = s.power_on;
    assign conversion_active_out = s.start_bit;
    assign converter_clk_tick_out = tick;
    assign precision_cpu_halt_out = s.precision && s.start_bit;
    // The request stays high until software clears the flag, which rearms it, or until the interrupt enable drops.
    assign converter_irq_out = s.done_flag
        && converter_irq_enable_in;

    a_pin_select_write: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        sfr_wr_in && sfr_addr_in == adcs_pkg::ADDR_PIN_SELECT
        |=> pin_analog_select_out == $past(sfr_wdata_in))
        else $error("Pin select did not take the written value.");

    a_done_sets_flag: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        s.start_bit && tick && s.clk_count == 4'hA
        |=> s.done_flag && s.result == $past(adc_data_in))
        else $error("Completed conversion did not set flag and result.");

    a_flag_holds_set: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        s.done_flag && !(wr_ctrl && !sfr_wdata_in[4]) |=> s.done_flag)
        else $error("Done flag cleared without a software zero write.");

    a_irq_follows_flag: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        $rose(s.done_flag) && converter_irq_enable_in |-> converter_irq_out)
        else $error("Interrupt not raised on new done flag.");

    a_divider_period: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        (tick && s.clk_div == 5'h00 && !double_speed_clock_mode_in)
        ##1 (s.start_bit && !tick && !double_speed_clock_mode_in)[*3]
        |=> tick)
        else $error("Converter clock period wrong for base four.");

    a_result_high_read: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        sfr_rd_in && sfr_addr_in == adcs_pkg::ADDR_RESULT_HIGH
        |=> sfr_rdata_out == $past(s.result[9:2]))
        else $error("High result read returned wrong bits.");

    a_result_low_read: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        sfr_rd_in && sfr_addr_in == adcs_pkg::ADDR_RESULT_LOW
        |=> sfr_rdata_out == {6'h00, $past(s.result[1:0])})
        else $error("Low result read returned wrong bits.");

    a_start_self_clear: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        $fell(s.start_bit) && s.power_on |-> s.done_flag)
        else $error("Start bit cleared without finishing a conversion.");

    a_channel_select: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_ctrl |=> input_channel_out == $past(sfr_wdata_in[2:0]))
        else $error("Channel field not updated by control write.");

    a_standby_idle: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        !s.power_on |-> !conversion_active_out && !tick)
        else $error("Conversion running in standby.");

    a_halt_released: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        $fell(precision_cpu_halt_out) && s.precision && s.power_on
        |-> s.done_flag)
        else $error("CPU halt released before the conversion ended.");

    a_start_refused_pin: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_ctrl && !s.pin_sel[sfr_wdata_in[2:0]] && !s.start_bit
        |=> !conversion_active_out)
        else $error("Start on an unrouted pin was not dropped.");

    a_flag_clear_write: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_ctrl && !sfr_wdata_in[adcs_pkg::CTRL_DONE_BIT]
        && !(s.start_bit && tick && s.clk_count == adcs_pkg::CONV_LAST)
        |=> !s.done_flag)
        else $error("Done flag not cleared by a software zero write.");

    a_start_needs_power: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_ctrl && !sfr_wdata_in[adcs_pkg::CTRL_POWER_BIT]
        |=> !conversion_active_out && !converter_power_on_out)
        else $error("Converter left running after a standby write.");

    a_start_launches: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        wr_ctrl && sfr_wdata_in[adcs_pkg::CTRL_START_BIT]
        && sfr_wdata_in[adcs_pkg::CTRL_POWER_BIT]
        && s.pin_sel[sfr_wdata_in[2:0]] && !s.start_bit
        |=> conversion_active_out && precision_cpu_halt_out
        == $past(sfr_wdata_in[adcs_pkg::CTRL_PRECISION_BIT]))
        else $error("Accepted start did not launch a conversion.");

    a_busy_holds: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        s.start_bit && !tick && s.power_on
        && !(wr_ctrl && !sfr_wdata_in[adcs_pkg::CTRL_POWER_BIT])
        |=> conversion_active_out && $stable(s.clk_count))
        else $error("Conversion stopped between converter clocks.");

    a_result_holds: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        !(s.start_bit && tick && s.clk_count == adcs_pkg::CONV_LAST)
        |=> $stable(s.result))
        else $error("Result changed without a finished conversion.");

    a_clock_field_write: assert property (
        @(posedge mclk_in) disable iff (!rst_b_in)
        sfr_wr_in && sfr_addr_in == adcs_pkg::ADDR_CLK_DIV
        |=> s.clk_div == $past(sfr_wdata_in[4:0]))
        else $error("Prescaler field not taken from the write.");
endmodule : adcs_sfr_control
`default_nettype wire

/* File: bench/adcs_sfr_control_tb_top.sv */
// Self-checking bench for the converter register block.
`default_nettype none
module adcs_sfr_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pins;
    logic wr = 1'b0, rd = 1'b0, irq_en = 1'b0, dbl = 1'b0;
    logic [9:0] adc = 10'h000;
    logic [2:0] chan;
    logic pwr, busy, tick, halt, irq;
    int error_cnt = 0, compares = 0, cyc = 0;

    adcs_sfr_control i_adcs_sfr_control (.mclk_in(mclk_in),
        .rst_b_in(rst_b_in), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .converter_irq_enable_in(irq_en),
        .double_speed_clock_mode_in(dbl), .adc_data_in(adc),
        .pin_analog_select_out(pins), .input_channel_out(chan),
        .converter_power_on_out(pwr), .conversion_active_out(busy),
        .converter_clk_tick_out(tick), .precision_cpu_halt_out(halt),
        .converter_irq_out(irq));

    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    // A hang is cut short well above the longest expected run.
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd_chk

    function automatic logic [15:0] exp_cycles(input logic [4:0] f,
                                               input logic x2);
        return 16'(11 * (x2 ? 2 : 4) * (f + 1));
    endfunction : exp_cycles

    // Counts busy cycles and prescaler ticks of one conversion.
    task automatic convert(input logic [2:0] ch, input logic prec,
                           output int n, output int t);
        n = 0;
        t = 0;
        wr_reg(adcs_pkg::ADDR_CONTROL, {1'b0, prec, 3'b101, ch});
        chk({15'h0, halt}, {15'h0, prec});
        while (busy === 1'b1 && n < 5000) begin
            n++;
            if (tick === 1'b1) t++;
            @(posedge mclk_in);
            #1;
        end
        chk({15'h0, halt}, 16'h0000);
    endtask : convert

    initial begin
        int n, t;
        logic [2:0] ch;
        logic [4:0] f;
        logic [7:0] ps;
        void'($urandom(72535));
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (int a = 8'hF2; a <= 8'hF7; a++) begin
            rd_chk(8'(a), 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            ch = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom);
            f = (i == 2) ? 5'h1F : 5'($urandom % 4);
            ps = 8'($urandom) | (8'h01 << ch);
            @(posedge mclk_in);
            dbl <= i[0];
            irq_en <= i[1];
            adc <= (i == 0) ? 10'h3FF : 10'($urandom);
            wr_reg(adcs_pkg::ADDR_CLK_DIV, {3'b111, f});
            rd_chk(adcs_pkg::ADDR_CLK_DIV, {3'b000, f});
            wr_reg(adcs_pkg::ADDR_PIN_SELECT, ps);
            rd_chk(adcs_pkg::ADDR_PIN_SELECT, ps);
            chk({8'h00, pins}, {8'h00, ps});
            convert(ch, i[2], n, t);
            chk(n[15:0], exp_cycles(f, i[0]));
            chk(t[15:0], 16'h000B);
            chk({13'h0, chan}, {13'h0, ch});
            rd_chk(adcs_pkg::ADDR_CONTROL, {1'b0, i[2], 3'b110, ch});
            chk({15'h0, irq}, {15'h0, i[1]});
            rd_chk(adcs_pkg::ADDR_RESULT_HIGH, adc[9:2]);
            rd_chk(adcs_pkg::ADDR_RESULT_LOW, {6'h00, adc[1:0]});
            wr_reg(adcs_pkg::ADDR_RESULT_HIGH, 8'hFF);
            rd_chk(adcs_pkg::ADDR_RESULT_HIGH, adc[9:2]);
            wr_reg(adcs_pkg::ADDR_CONTROL, 8'h20);
            chk({15'h0, irq}, 16'h0000);
            rd_chk(adcs_pkg::ADDR_CONTROL, 8'h20);
        end
        wr_reg(adcs_pkg::ADDR_PIN_SELECT, 8'hFE);
        wr_reg(adcs_pkg::ADDR_CONTROL, 8'h28);
        rd_chk(adcs_pkg::ADDR_CONTROL, 8'h20);
        wr_reg(adcs_pkg::ADDR_PIN_SELECT, 8'h01);
        wr_reg(adcs_pkg::ADDR_CONTROL, 8'h08);
        rd_chk(adcs_pkg::ADDR_CONTROL, 8'h00);
        chk({15'h0, pwr}, 16'h0000);
        wr_reg(adcs_pkg::ADDR_CONTROL, 8'h28);
        repeat (5) @(posedge mclk_in);
        wr_reg(adcs_pkg::ADDR_CONTROL, 8'h00);
        repeat (300) @(posedge mclk_in);
        #1;
        rd_chk(adcs_pkg::ADDR_CONTROL, 8'h00);
        chk({15'h0, busy}, 16'h0000);
        finish_test();
    end
endmodule : adcs_sfr_control_tb_top
`default_nettype wire
